// [wdt_pkg.sv]
// Constants, types and register map of the indexed-port watchdog timer.
// Assumes a 125 MHz core clock and a host issuing single-cycle I/O strobes.
//
// Overview of operation
// - Host writes a register index to the index port, then accesses it via data.
// - Two consecutive unlock key writes to the index port open configuration.
// - Writing 08h to index 07h selects the watchdog register group.
// - Writing 01h to index 30h enables the watchdog; off after reset.
// - Index F5h bit 3 picks unit: zero seconds (reset), one minutes.
// - Index F6h holds timeout 01h to FFh; zero stops the timer.
// - Any write to index F6h restarts countdown from the new value.
// - Countdown expiring without a strobe asserts the timeout output.
// - F7h bit 6 set lets keyboard activity restart the countdown.
// - Writing one to F7h bit 5 forces a timeout, bit self-clears.
// - F7h bit 4 reads one once the timer expired, reset zero.
// - Writing the lock key to the index port ends configuration.
// - F7h bit 7 set lets mouse activity restart the countdown.
package wdt_pkg;

    // ----------------------------------------------------------------
    // Ports and keys
    // ----------------------------------------------------------------
    localparam logic [15:0] INDEX_PORT = 16'h002E;
    localparam logic [15:0] DATA_PORT = 16'h002F;
    localparam logic [7:0] UNLOCK_KEY = 8'h87;
    localparam logic [7:0] LOCK_KEY = 8'hAA;

    // ----------------------------------------------------------------
    // Register indices and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_GROUP_SEL = 8'h07;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_UNIT = 8'hF5;
    localparam logic [7:0] IDX_COUNT = 8'hF6;
    localparam logic [7:0] IDX_CTRL = 8'hF7;
    localparam logic [7:0] GROUP_WDT = 8'h08;
    localparam int ACT_BIT = 0;
    localparam int UNIT_BIT = 3;
    localparam int STATUS_BIT = 4;
    localparam int FORCE_BIT = 5;
    localparam int KBD_EN_BIT = 6;
    localparam int MOUSE_EN_BIT = 7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_GROUP = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_S = 1;
    localparam int NS_PER_S = 1000000000;
    localparam int SEC_CYCLES = TICK_PERIOD_S * (NS_PER_S / CLK_PERIOD_NS);
    localparam logic [5:0] SEC_PER_MIN = 6'd60;
    localparam int PRESC_W = 27;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {CFG_LOCKED, CFG_KEY1, CFG_OPEN} cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } io_rsp_t;

    typedef struct packed {
        cfg_t cfg;
        logic [7:0] idx;
        logic [7:0] group;
        logic active;
        logic unit_min;
        logic [7:0] count;
        logic kbd_en;
        logic mouse_en;
        logic status;
        logic [7:0] remain;
        logic [PRESC_W-1:0] presc;
        logic [5:0] minute;
        logic [7:0] rdata;
        logic rvalid;
        logic [1:0] kbd_s;
        logic [1:0] mouse_s;
        logic kbd_d;
        logic mouse_d;
    } wdt_state_t;

endpackage : wdt_pkg

// [wdt_top.sv]
// Watchdog timer behind an index/data I/O port pair.
// Assumes host strobes are synchronous to I_CLK; activity pins are not.
`timescale 1ns/10ps
`default_nettype none
module wdt_top
    import wdt_pkg::*;
#(
    parameter int unsigned P_SEC_CYCLES = SEC_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire io_req_t I_IO_REQ,
    output io_rsp_t O_IO_RSP,
    input wire logic I_KBD_ACT,
    input wire logic I_MOUSE_ACT,
    output logic O_WDT_TIMEOUT
);

    wdt_state_t s_q;
    wdt_state_t s_d;

    logic wr_idx, wr_dat, rd_any, sel, open;
    logic w_act, w_unit, w_cnt, w_ctrl, force_to;
    logic kbd_ev, mouse_ev, reload, running, sec_tick, unit_tick, expire;
    logic [PRESC_W-1:0] presc_last;

    // ----------------------------------------------------------------
    // Port decode
    // ----------------------------------------------------------------
    assign presc_last = PRESC_W'(P_SEC_CYCLES - 1);
    assign open = (s_q.cfg == CFG_OPEN);
    assign wr_idx = I_IO_REQ.wr && (I_IO_REQ.addr == INDEX_PORT);
    assign wr_dat = I_IO_REQ.wr && (I_IO_REQ.addr == DATA_PORT) && open;
    assign rd_any = I_IO_REQ.rd &&
        ((I_IO_REQ.addr == INDEX_PORT) || (I_IO_REQ.addr == DATA_PORT));
    assign sel = (s_q.group == GROUP_WDT);
    assign w_act = wr_dat && sel && (s_q.idx == IDX_ACTIVATE);
    assign w_unit = wr_dat && sel && (s_q.idx == IDX_UNIT);
    assign w_cnt = wr_dat && sel && (s_q.idx == IDX_COUNT);
    assign w_ctrl = wr_dat && sel && (s_q.idx == IDX_CTRL);
    assign force_to = w_ctrl && I_IO_REQ.wdata[FORCE_BIT];

    // ----------------------------------------------------------------
    // Countdown control
    // ----------------------------------------------------------------
    assign kbd_ev = s_q.kbd_s[1] && !s_q.kbd_d && s_q.kbd_en;
    assign mouse_ev = s_q.mouse_s[1] && !s_q.mouse_d && s_q.mouse_en;
    assign reload = (kbd_ev || mouse_ev) && s_q.active && !w_cnt;
    assign running = s_q.active && (s_q.count != 8'h00) &&
        (s_q.remain != 8'h00);
    assign sec_tick = running && !reload && (s_q.presc == presc_last);
    assign unit_tick = sec_tick &&
        (!s_q.unit_min || (s_q.minute == SEC_PER_MIN - 6'd1));
    assign expire = unit_tick && !w_cnt && (s_q.remain == 8'h01);

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.kbd_s = {s_q.kbd_s[0], I_KBD_ACT};
        s_d.mouse_s = {s_q.mouse_s[0], I_MOUSE_ACT};
        s_d.kbd_d = s_q.kbd_s[1];
        s_d.mouse_d = s_q.mouse_s[1];

        // Key sequence and index capture
        if (wr_idx) begin
            case (s_q.cfg)
                CFG_LOCKED: begin
                    if (I_IO_REQ.wdata == UNLOCK_KEY) begin
                        s_d.cfg = CFG_KEY1;
                    end
                end
                CFG_KEY1: begin
                    s_d.cfg = (I_IO_REQ.wdata == UNLOCK_KEY) ?
                        CFG_OPEN : CFG_LOCKED;
                end
                CFG_OPEN: begin
                    if (I_IO_REQ.wdata == LOCK_KEY) begin
                        s_d.cfg = CFG_LOCKED;
                    end else begin
                        s_d.idx = I_IO_REQ.wdata;
                    end
                end
                default: s_d.cfg = CFG_LOCKED;
            endcase
        end

        // Data port writes routed by the current index
        if (wr_dat && (s_q.idx == IDX_GROUP_SEL)) begin
            s_d.group = I_IO_REQ.wdata;
        end
        if (w_act) begin
            s_d.active = I_IO_REQ.wdata[ACT_BIT];
        end
        if (w_unit) begin
            s_d.unit_min = I_IO_REQ.wdata[UNIT_BIT];
        end
        if (w_ctrl) begin
            s_d.kbd_en = I_IO_REQ.wdata[KBD_EN_BIT];
            s_d.mouse_en = I_IO_REQ.wdata[MOUSE_EN_BIT];
        end

        // Prescaler and countdown
        if (w_cnt || reload || !running || sec_tick) begin
            s_d.presc = '0;
        end else begin
            s_d.presc = s_q.presc + PRESC_W'(1);
        end
        if (w_cnt || reload || !running || unit_tick) begin
            s_d.minute = 6'd0;
        end else if (sec_tick) begin
            s_d.minute = s_q.minute + 6'd1;
        end
        if (w_cnt) begin
            s_d.count = I_IO_REQ.wdata;
            s_d.remain = I_IO_REQ.wdata;
        end else if (reload) begin
            s_d.remain = s_q.count;
        end else if (unit_tick) begin
            s_d.remain = s_q.remain - 8'd1;
        end

        // Status: a count write clears it and suppresses expiry in its cycle; force sets it
        if (w_cnt) begin
            s_d.status = 1'b0;
        end
        if (expire || force_to) begin
            s_d.status = 1'b1;
        end

        // Read data
        if (rd_any) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = 8'h00;
            if (open && (I_IO_REQ.addr == INDEX_PORT)) begin
                s_d.rdata = s_q.idx;
            end else if (open) begin
                case (s_q.idx)
                    IDX_GROUP_SEL: s_d.rdata = s_q.group;
                    IDX_ACTIVATE: s_d.rdata = sel ? {7'd0, s_q.active} : 8'h00;
                    IDX_UNIT: s_d.rdata = sel ? {4'd0, s_q.unit_min, 3'd0} : 8'h00;
                    IDX_COUNT: s_d.rdata = sel ? s_q.count : 8'h00;
                    IDX_CTRL: s_d.rdata = sel ? {s_q.mouse_en, s_q.kbd_en,
                        1'b0, s_q.status, 4'd0} : 8'h00;
                    default: s_d.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            s_q <= '0;
            s_q.cfg <= CFG_LOCKED;
            s_q.idx <= RST_INDEX;
            s_q.group <= RST_GROUP;
            s_q.count <= RST_COUNT;
            s_q.remain <= RST_COUNT;
            s_q.rdata <= RST_RDATA;
        end else begin
            s_q <= s_d;
        end
    end

    assign O_IO_RSP = '{rdata: s_q.rdata, rvalid: s_q.rvalid};
    assign O_WDT_TIMEOUT = s_q.status;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    sequence key_wr;
        wr_idx && (I_IO_REQ.wdata == UNLOCK_KEY);
    endsequence
    sequence locked_key;
        (s_q.cfg == CFG_LOCKED) and key_wr;
    endsequence
    sequence locked_key_pair;
        locked_key ##1 key_wr;
    endsequence

    AST_UNLOCK_PAIR: assert property (locked_key_pair |=> open)
        else $error("Two unlock keys did not open configuration");
    AST_ONE_KEY_STAYS_SHUT: assert property (
        locked_key |=> !open)
        else $error("Single unlock key opened configuration");
    AST_LOCK_KEY: assert property (
        open && wr_idx && (I_IO_REQ.wdata == LOCK_KEY) |=>
        (s_q.cfg == CFG_LOCKED))
        else $error("Lock key did not close configuration");
    AST_INDEX_CAPTURE: assert property (
        open && wr_idx && (I_IO_REQ.wdata != LOCK_KEY) |=>
        s_q.idx == $past(I_IO_REQ.wdata))
        else $error("Index not captured");
    AST_READ_ANSWER: assert property (
        O_IO_RSP.rvalid == $past(rd_any))
        else $error("Port read answer not one cycle after request");
    AST_LOCKED_INERT: assert property (
        !open && I_IO_REQ.wr && (I_IO_REQ.addr == DATA_PORT) |=>
        $stable(s_q.count) && $stable(s_q.active) && $stable(s_q.group))
        else $error("Locked data write changed a register");
    AST_OFF_AFTER_RESET: assert property (
        $fell(I_RST) |-> !s_q.active && !O_WDT_TIMEOUT)
        else $error("Watchdog not off after reset");
    AST_COUNT_RELOAD: assert property (
        w_cnt |=> s_q.remain == $past(I_IO_REQ.wdata) &&
        s_q.presc == '0)
        else $error("Count write did not restart countdown");
    AST_ZERO_STOPS: assert property (
        (s_q.count == 8'h00) && !force_to && !O_WDT_TIMEOUT && !w_cnt |=>
        !O_WDT_TIMEOUT)
        else $error("Timeout with zero count");
    AST_FORCE: assert property (
        force_to |=> O_WDT_TIMEOUT ##1 O_WDT_TIMEOUT)
        else $error("Forced timeout not produced");
    AST_EXPIRE: assert property (
        running && unit_tick && (s_q.remain == 8'h01) && !w_cnt |=>
        O_WDT_TIMEOUT && (s_q.remain == 8'h00))
        else $error("Expiry missed");
    AST_KBD_RESTART: assert property (
        kbd_ev && s_q.active && !w_cnt |=> s_q.remain == $past(s_q.count))
        else $error("Keyboard activity did not restart");
    AST_MOUSE_RESTART: assert property (
        mouse_ev && s_q.active && !w_cnt |=> s_q.remain == $past(s_q.count))
        else $error("Mouse activity did not restart");
    AST_STATUS_READ: assert property (
        open && sel && I_IO_REQ.rd && (I_IO_REQ.addr == DATA_PORT) &&
        (s_q.idx == IDX_CTRL) |=>
        O_IO_RSP.rvalid && O_IO_RSP.rdata[STATUS_BIT] == $past(s_q.status))
        else $error("Status bit read wrong");

endmodule : wdt_top
`default_nettype wire

// [host_bfm.sv]
// Host model: single-cycle I/O writes and reads on the index/data ports.
// Assumes the device answers a read one cycle after the request edge.
`timescale 1ns/10ps
`default_nettype none
module host_bfm
    import wdt_pkg::*;
(
    input wire logic i_clk,
    input wire io_rsp_t i_rsp,
    output io_req_t o_req
);
    // ------------------------------------------------------------------
    // Port cycles
    // ------------------------------------------------------------------
    initial begin
        o_req = '0;
    end
    // Request changes 1 ns after an edge and is taken at the next edge
    task automatic put(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_clk);
        #1;
        // Released lines show the inverse, not the last value
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : put
    task automatic get(input logic [15:0] a, output logic [7:0] d,
                       output logic v);
        put(1'b0, a, 8'h00);
        d = i_rsp.rdata;
        v = i_rsp.rvalid;
    endtask : get
endmodule : host_bfm
`default_nettype wire

// [wdt_top_tb.sv]
// Self-checking bench of wdt_top: each scenario drives the I/O ports
// through host_bfm. Assumes a 125 MHz clock and P_SEC_CYCLES of 10.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module wdt_top_tb
    import wdt_pkg::*;
;
    // ------------------------------------------------------------------
    // Setup and shared tasks
    // ------------------------------------------------------------------
    localparam int SEC = 10;
    logic clk;
    logic rst = 1'b1;
    logic kbd = 1'b0;
    logic mouse = 1'b0;
    logic tmo;
    io_req_t req;
    io_rsp_t rsp;
    logic [7:0] d;
    logic v;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    wdt_top #(.P_SEC_CYCLES(SEC)) i_wdt_top (.I_CLK(clk), .I_RST(rst),
        .I_IO_REQ(req), .O_IO_RSP(rsp), .I_KBD_ACT(kbd),
        .I_MOUSE_ACT(mouse), .O_WDT_TIMEOUT(tmo));
    host_bfm i_host_bfm (.i_clk(clk), .i_rsp(rsp), .o_req(req));
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic key(input logic [7:0] k);
        i_host_bfm.put(1'b1, INDEX_PORT, k);
    endtask : key
    task automatic wreg(input logic [7:0] i, input logic [7:0] x);
        key(i);
        i_host_bfm.put(1'b1, DATA_PORT, x);
    endtask : wreg
    task automatic rreg(input logic [7:0] i);
        key(i);
        i_host_bfm.get(DATA_PORT, d, v);
        `CHK("rvalid", 1'b1, v)
    endtask : rreg
    task automatic wait_to(input int n, input logic e);
        repeat (n) @(posedge clk);
        #1;
        `CHK("timeout", e, tmo)
    endtask : wait_to
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_locked;
        wait_to(1, 1'b0);
        key(UNLOCK_KEY);
        key(IDX_COUNT);
        key(UNLOCK_KEY);
        wreg(IDX_ACTIVATE, 8'h01);
        wreg(IDX_COUNT, 8'h01);
        wait_to(4 * SEC, 1'b0);
        i_host_bfm.get(DATA_PORT, d, v);
        `CHK("locked read", 8'h00, d)
        i_host_bfm.get(INDEX_PORT, d, v);
        `CHK("locked index", 8'h00, d)
    endtask : t_locked
    task automatic t_group;
        key(UNLOCK_KEY);
        key(UNLOCK_KEY);
        wreg(IDX_COUNT, 8'h03);
        rreg(IDX_COUNT);
        `CHK("other group", 8'h00, d)
        wreg(IDX_GROUP_SEL, GROUP_WDT);
        wreg(IDX_COUNT, 8'h01);
        rreg(IDX_COUNT);
        `CHK("count", 8'h01, d)
        wait_to(4 * SEC, 1'b0);
        rreg(IDX_UNIT);
        `CHK("unit reset", 8'h00, d)
        rreg(IDX_ACTIVATE);
        `CHK("active reset", 8'h00, d)
        i_host_bfm.get(INDEX_PORT, d, v);
        `CHK("index read", IDX_ACTIVATE, d)
        wreg(IDX_ACTIVATE, 8'h01);
    endtask : t_group
    task automatic t_expire;
        wreg(IDX_COUNT, 8'h03);
        wait_to(3 * SEC - 12, 1'b0);
        wait_to(15, 1'b1);
        rreg(IDX_CTRL);
        `CHK("status", 8'h10, d)
        rreg(IDX_ACTIVATE);
        `CHK("active", 8'h01, d)
        wreg(IDX_COUNT, 8'h03);
        wait_to(0, 1'b0);
        repeat (3) begin
            wait_to(14, 1'b0);
            wreg(IDX_COUNT, 8'h03);
        end
        wreg(IDX_COUNT, 8'h00);
        wait_to(30 * SEC, 1'b0);
        wreg(IDX_CTRL, 8'h20);
        wait_to(0, 1'b1);
        rreg(IDX_CTRL);
        `CHK("force cleared", 8'h10, d)
    endtask : t_expire
    task automatic t_activity;
        for (int k = 0; k < 2; k++) begin
            for (int en = 1; en >= 0; en--) begin
                wreg(IDX_CTRL, en == 0 ? 8'h00 : (k == 0 ? 8'h40 : 8'h80));
                wreg(IDX_COUNT, 8'h03);
                repeat (5) begin
                    if (k == 0) begin
                        kbd = 1'b1;
                    end else begin
                        mouse = 1'b1;
                    end
                    repeat (3) @(posedge clk);
                    #1;
                    kbd = 1'b0;
                    mouse = 1'b0;
                    repeat (12) @(posedge clk);
                    #1;
                end
                `CHK("activity", en == 0, tmo)
            end
        end
    endtask : t_activity
    task automatic t_unit_lock;
        wreg(IDX_UNIT, 8'h08);
        rreg(IDX_UNIT);
        `CHK("unit", 8'h08, d)
        wreg(IDX_COUNT, 8'h02);
        wait_to(55 * SEC, 1'b0);
        wait_to(70 * SEC, 1'b1);
        wreg(IDX_UNIT, 8'h00);
        wreg(IDX_COUNT, 8'h00);
        key(LOCK_KEY);
        wreg(IDX_COUNT, 8'h05);
        i_host_bfm.get(DATA_PORT, d, v);
        `CHK("after lock", 8'h00, d)
        key(UNLOCK_KEY);
        key(UNLOCK_KEY);
        wreg(IDX_GROUP_SEL, GROUP_WDT);
        rreg(IDX_COUNT);
        `CHK("count kept", 8'h00, d)
    endtask : t_unit_lock
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_locked();
        t_group();
        t_expire();
        t_activity();
        t_unit_lock();
        print_verdict();
    end
endmodule : wdt_top_tb
`default_nettype wire
